// ---- hw/dcpll_regs.svh ----
// register offsets, field positions, reset values and counts for the sample-clock pll control
`ifndef DCPLL_REGS_SVH
`define DCPLL_REGS_SVH

`define DCPLL_ADDR_W 12
`define DCPLL_OFS_IRQ_ENABLE 12'h01f
`define DCPLL_OFS_IRQ_STATUS 12'h023
`define DCPLL_OFS_PLL_CONTROL 12'h083
`define DCPLL_OFS_STATE_FLAGS 12'h084
`define DCPLL_OFS_LOOP_DIVIDE 12'h085
`define DCPLL_OFS_OSC_DIVIDE 12'h08b
`define DCPLL_OFS_REF_DIVIDE 12'h08c
`define DCPLL_OFS_TUNE_A 12'h1b5
`define DCPLL_OFS_TUNE_B 12'h1bb
`define DCPLL_OFS_TUNE_C 12'h1c5

`define DCPLL_RST_BYTE 8'h00

`define DCPLL_CTRL_ENABLE_BIT 4
`define DCPLL_CTRL_RECAL_BIT 7
`define DCPLL_FLAG_LOCK_BIT 1
`define DCPLL_FLAG_CALDONE_BIT 5
`define DCPLL_FLAG_LOWER_BIT 6
`define DCPLL_FLAG_UPPER_BIT 7
`define DCPLL_IRQ_LOCK_BIT 5
`define DCPLL_IRQ_LOST_BIT 4

`define DCPLL_CP_CAL_REF_CYCLES 7'd64
`define DCPLL_BAND_SETTLE_REF_CYCLES 7'd4
`define DCPLL_BAND_START 9'h100
`define DCPLL_BAND_TOP_BIT 4'h8

`endif

// ---- hw/dcpll_pkg.sv ----
// types shared by the sample-clock pll control block
package dcpll_pkg;

    typedef enum logic [1:0] {
        DCPLL_IDLE,
        DCPLL_CP_CAL,
        DCPLL_BAND_SEARCH,
        DCPLL_TRACK
    } dcpll_state_e;

    typedef struct packed {
        dcpll_state_e state;
        logic [6:0] ref_cnt;
        logic [8:0] band;
        logic [3:0] bit_pos;
        logic cp_done;
        logic cal_done;
        logic [7:0] irq_enable;
        logic [1:0] irq_status;
        logic [7:0] pll_control;
        logic [7:0] loop_divide_count;
        logic [7:0] osc_divide;
        logic [7:0] ref_divide;
        logic [7:0] tune_a;
        logic [7:0] tune_b;
        logic [7:0] tune_c;
        logic [7:0] rdata;
    } dcpll_state_s;

endpackage : dcpll_pkg

// ---- hw/dcpll_edge.sv ----
// registered-history edge detector for one level
`timescale 1ns/1ps
`default_nettype none
module dcpll_edge (
    input wire logic core_clk_i, // core clock
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic level_i, // level to watch
    output logic rise_o, // high while level rose this cycle
    output logic fall_o // high while level fell this cycle
);
    typedef struct packed {
        logic prev;
    } dcpll_edge_s;

    dcpll_edge_s st_r;
    dcpll_edge_s st_nxt;

    always_comb begin
        st_nxt.prev = level_i;
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rise_o = level_i & ~st_r.prev;
    assign fall_o = ~level_i & st_r.prev;
endmodule : dcpll_edge
`default_nettype wire

// ---- hw/dcpll_ctrl.sv ----
// register file, band calibration sequencer and lock events of the sample-clock pll
// What this block does
// - once enabled, the block picks one of 512 oscillator bands by itself.
// - pll locked appears on bit 1 of the pll state flags register.
// - setting the enable bit of pll control starts the pll; done last.
// - a status bit shows that calibration finished and its result is valid.
// - bit 7 flags upper band edge, bit 6 flags lower band edge.
// - writing recalibrate bit zero then one makes the block recalibrate.
// - lock and lost events are gated by enable bits 5 and 4.
// - lock and lost status sit in bits 5 and 4, cleared there.
// - oscillator divide select 1, 2, 3 means divide by 4, 8, 16.
// - reference divide select 0 to 4 means divide by 1 to 16.
// - first start runs 64 reference cycles of charge pump calibration, kept afterwards.
`timescale 1ns/1ps
`default_nettype none
`include "dcpll_regs.svh"
module dcpll_ctrl (
    input wire logic core_clk_i, // core clock, 50 MHz
    input wire logic sys_rst_i, // sync reset, active high
    input wire logic reg_wr_i, // register write strobe
    input wire logic reg_rd_i, // register read strobe
    input wire logic [`DCPLL_ADDR_W-1:0] reg_addr_i, // register address
    input wire logic [7:0] reg_wdata_i, // register write data
    output logic [7:0] reg_rdata_o, // read data, valid cycle after read strobe
    input wire logic ref_tick_i, // one pulse per reference clock cycle
    input wire logic vco_fast_i, // oscillator above target at current band
    input wire logic pll_lock_i, // analog lock detector
    input wire logic tune_upper_i, // tuning voltage at upper edge
    input wire logic tune_lower_i, // tuning voltage at lower edge
    output logic pll_enable_o, // synthesizer power
    output logic cp_cal_run_o, // charge pump calibration running
    output logic [8:0] band_select_o, // oscillator band
    output logic [7:0] loop_divide_count_o, // loop divider count
    output logic [4:0] oscillator_output_divide_ratio_o, // 4, 8 or 16; 0 when invalid
    output logic [4:0] reference_divide_ratio_o, // 1 to 16; 0 when invalid
    output logic [7:0] tune_a_o, // oscillator tuning a
    output logic [7:0] tune_b_o, // oscillator tuning b
    output logic [7:0] tune_c_o, // oscillator tuning c
    output logic irq_o // pending enabled pll event
);
    dcpll_pkg::dcpll_state_s st_r;
    dcpll_pkg::dcpll_state_s st_nxt;

    logic enabled;
    logic locked;
    logic edge_upper;
    logic edge_lower;
    logic recal_rise;
    logic lock_rise;
    logic lock_fall;
    logic [7:0] flags;
    logic [1:0] irq_clear;

    assign enabled = st_r.pll_control[`DCPLL_CTRL_ENABLE_BIT];
    assign locked = pll_lock_i && st_r.cal_done;
    assign edge_upper = tune_upper_i && st_r.cal_done;
    assign edge_lower = tune_lower_i && st_r.cal_done;
    assign flags = {edge_upper, edge_lower, st_r.cal_done, 3'h0, locked, 1'b0};

    // recalibration only on the zero-to-one step of the stored bit
    dcpll_edge u_recal_edge (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(st_r.pll_control[`DCPLL_CTRL_RECAL_BIT]),
        .rise_o(recal_rise),
        .fall_o()
    );

    dcpll_edge u_lock_edge (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .level_i(locked),
        .rise_o(lock_rise),
        .fall_o(lock_fall)
    );

    assign irq_clear = (reg_wr_i && reg_addr_i == `DCPLL_OFS_IRQ_STATUS) ?
        reg_wdata_i[`DCPLL_IRQ_LOCK_BIT:`DCPLL_IRQ_LOST_BIT] : 2'h0;

    always_comb begin
        st_nxt = st_r;
        // write one to clear; a new event in the same cycle still wins
        st_nxt.irq_status = (st_r.irq_status & ~irq_clear) | {lock_rise, lock_fall};
        if (reg_wr_i) begin
            if (reg_addr_i == `DCPLL_OFS_IRQ_ENABLE) begin
                st_nxt.irq_enable = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_PLL_CONTROL) begin
                st_nxt.pll_control = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_LOOP_DIVIDE) begin
                st_nxt.loop_divide_count = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_OSC_DIVIDE) begin
                st_nxt.osc_divide = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_REF_DIVIDE) begin
                st_nxt.ref_divide = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_A) begin
                st_nxt.tune_a = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_B) begin
                st_nxt.tune_b = reg_wdata_i;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_C) begin
                st_nxt.tune_c = reg_wdata_i;
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `DCPLL_OFS_IRQ_ENABLE) begin
                st_nxt.rdata = st_r.irq_enable;
            end else if (reg_addr_i == `DCPLL_OFS_IRQ_STATUS) begin
                st_nxt.rdata = {2'h0, st_r.irq_status, 4'h0};
            end else if (reg_addr_i == `DCPLL_OFS_PLL_CONTROL) begin
                st_nxt.rdata = st_r.pll_control;
            end else if (reg_addr_i == `DCPLL_OFS_STATE_FLAGS) begin
                st_nxt.rdata = flags;
            end else if (reg_addr_i == `DCPLL_OFS_LOOP_DIVIDE) begin
                st_nxt.rdata = st_r.loop_divide_count;
            end else if (reg_addr_i == `DCPLL_OFS_OSC_DIVIDE) begin
                st_nxt.rdata = st_r.osc_divide;
            end else if (reg_addr_i == `DCPLL_OFS_REF_DIVIDE) begin
                st_nxt.rdata = st_r.ref_divide;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_A) begin
                st_nxt.rdata = st_r.tune_a;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_B) begin
                st_nxt.rdata = st_r.tune_b;
            end else if (reg_addr_i == `DCPLL_OFS_TUNE_C) begin
                st_nxt.rdata = st_r.tune_c;
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
        case (st_r.state)
            dcpll_pkg::DCPLL_IDLE: begin
                if (enabled) begin
                    st_nxt.ref_cnt = 7'h00;
                    st_nxt.band = `DCPLL_BAND_START;
                    st_nxt.bit_pos = `DCPLL_BAND_TOP_BIT;
                    // charge pump coefficient survives disable, so later starts skip it
                    st_nxt.state = st_r.cp_done ? dcpll_pkg::DCPLL_BAND_SEARCH :
                        dcpll_pkg::DCPLL_CP_CAL;
                end
            end
            dcpll_pkg::DCPLL_CP_CAL: begin
                if (ref_tick_i) begin
                    st_nxt.ref_cnt = st_r.ref_cnt + 7'h01;
                    if (st_r.ref_cnt == `DCPLL_CP_CAL_REF_CYCLES - 7'h01) begin
                        st_nxt.cp_done = 1'b1;
                        st_nxt.ref_cnt = 7'h00;
                        st_nxt.state = dcpll_pkg::DCPLL_BAND_SEARCH;
                    end
                end
            end
            dcpll_pkg::DCPLL_BAND_SEARCH: begin
                // binary search over the bands, one bit per settle window
                if (ref_tick_i) begin
                    st_nxt.ref_cnt = st_r.ref_cnt + 7'h01;
                    if (st_r.ref_cnt == `DCPLL_BAND_SETTLE_REF_CYCLES - 7'h01) begin
                        st_nxt.ref_cnt = 7'h00;
                        st_nxt.band[st_r.bit_pos] = ~vco_fast_i;
                        if (st_r.bit_pos == 4'h0) begin
                            st_nxt.cal_done = 1'b1;
                            st_nxt.state = dcpll_pkg::DCPLL_TRACK;
                        end else begin
                            st_nxt.band[st_r.bit_pos - 4'h1] = 1'b1;
                            st_nxt.bit_pos = st_r.bit_pos - 4'h1;
                        end
                    end
                end
            end
            dcpll_pkg::DCPLL_TRACK: begin
                if (recal_rise) begin
                    st_nxt.cal_done = 1'b0;
                    st_nxt.ref_cnt = 7'h00;
                    st_nxt.band = `DCPLL_BAND_START;
                    st_nxt.bit_pos = `DCPLL_BAND_TOP_BIT;
                    st_nxt.state = dcpll_pkg::DCPLL_BAND_SEARCH;
                end
            end
            default: begin
                st_nxt.state = dcpll_pkg::DCPLL_IDLE;
            end
        endcase
        if (!enabled) begin
            st_nxt.state = dcpll_pkg::DCPLL_IDLE;
            st_nxt.cal_done = 1'b0;
            // an unfinished charge pump run is simply restarted next time
            st_nxt.ref_cnt = 7'h00;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (sys_rst_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_comb begin
        case (st_r.osc_divide[1:0])
            2'h1: oscillator_output_divide_ratio_o = 5'h04;
            2'h2: oscillator_output_divide_ratio_o = 5'h08;
            2'h3: oscillator_output_divide_ratio_o = 5'h10;
            default: oscillator_output_divide_ratio_o = 5'h00;
        endcase
        case (st_r.ref_divide[2:0])
            3'h0: reference_divide_ratio_o = 5'h01;
            3'h1: reference_divide_ratio_o = 5'h02;
            3'h2: reference_divide_ratio_o = 5'h04;
            3'h3: reference_divide_ratio_o = 5'h08;
            3'h4: reference_divide_ratio_o = 5'h10;
            default: reference_divide_ratio_o = 5'h00;
        endcase
    end

    assign reg_rdata_o = st_r.rdata;
    assign pll_enable_o = enabled;
    assign cp_cal_run_o = (st_r.state == dcpll_pkg::DCPLL_CP_CAL);
    assign band_select_o = st_r.band;
    assign loop_divide_count_o = st_r.loop_divide_count;
    assign tune_a_o = st_r.tune_a;
    assign tune_b_o = st_r.tune_b;
    assign tune_c_o = st_r.tune_c;
    assign irq_o = |(st_r.irq_status & st_r.irq_enable[`DCPLL_IRQ_LOCK_BIT:`DCPLL_IRQ_LOST_BIT]);

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_search_last_step;
        st_r.state == dcpll_pkg::DCPLL_BAND_SEARCH && st_r.bit_pos == 4'h0;
    endsequence
    sequence s_track_entered;
        st_r.state == dcpll_pkg::DCPLL_TRACK && st_r.cal_done;
    endsequence

    property p_band_auto;
        $rose(st_r.cal_done) |-> $past(st_r.state == dcpll_pkg::DCPLL_BAND_SEARCH && st_r.bit_pos == 4'h0);
    endproperty
    a_band_auto: assert property (p_band_auto) else $error("band chosen without search");

    property p_lock_flag;
        reg_rd_i && reg_addr_i == `DCPLL_OFS_STATE_FLAGS |=> reg_rdata_o[1] == $past(pll_lock_i && st_r.cal_done);
    endproperty
    a_lock_flag: assert property (p_lock_flag) else $error("lock flag misreported");

    property p_enable_start;
        st_r.state == dcpll_pkg::DCPLL_IDLE && enabled && !st_r.cp_done |=> cp_cal_run_o;
    endproperty
    a_enable_start: assert property (p_enable_start) else $error("enable did not start pll");

    property p_cp_kept;
        st_r.cp_done |=> st_r.cp_done;
    endproperty
    a_cp_kept: assert property (p_cp_kept) else $error("charge pump result lost");

    property p_cp_len;
        $rose(st_r.cp_done) |-> $past(st_r.ref_cnt) == 7'd63 && $past(ref_tick_i);
    endproperty
    a_cp_len: assert property (p_cp_len) else $error("charge pump run length wrong");

    property p_caldone;
        s_search_last_step ##0 ref_tick_i ##0 st_r.ref_cnt == 7'd3 ##0 enabled |=> s_track_entered;
    endproperty
    a_caldone: assert property (p_caldone) else $error("calibration done not flagged");

    property p_edge_flag;
        reg_rd_i && reg_addr_i == `DCPLL_OFS_STATE_FLAGS |=>
            reg_rdata_o[7:6] == $past({tune_upper_i, tune_lower_i} & {2{st_r.cal_done}});
    endproperty
    a_edge_flag: assert property (p_edge_flag) else $error("band edge flags wrong");

    property p_recal;
        st_r.state == dcpll_pkg::DCPLL_TRACK && recal_rise && enabled |=>
            st_r.state == dcpll_pkg::DCPLL_BAND_SEARCH && !st_r.cal_done ##1 !st_r.cal_done;
    endproperty
    a_recal: assert property (p_recal) else $error("recalibration not started");

    property p_irq_gate;
        irq_o |-> (st_r.irq_status[1] && st_r.irq_enable[5]) || (st_r.irq_status[0] && st_r.irq_enable[4]);
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

    property p_lock_event;
        $rose(locked) |=> st_r.irq_status[1];
    endproperty
    a_lock_event: assert property (p_lock_event) else $error("lock event lost");

    property p_clear;
        reg_wr_i && reg_addr_i == `DCPLL_OFS_IRQ_STATUS && reg_wdata_i[5] && !lock_rise |=> !st_r.irq_status[1];
    endproperty
    a_clear: assert property (p_clear) else $error("lock status not cleared");

    property p_osc_div;
        st_r.osc_divide[1:0] == 2'h2 |-> oscillator_output_divide_ratio_o == 5'd8;
    endproperty
    a_osc_div: assert property (p_osc_div) else $error("oscillator divide decode wrong");

    property p_ref_div;
        st_r.ref_divide[2:0] == 3'h3 |-> reference_divide_ratio_o == 5'd8;
    endproperty
    a_ref_div: assert property (p_ref_div) else $error("reference divide decode wrong");
endmodule : dcpll_ctrl
`default_nettype wire

// ---- tb/tb_dcpll_ctrl.sv ----
// self-checking testbench for the sample-clock pll control block
`timescale 1ns/1ps
`default_nettype none
`include "dcpll_regs.svh"
module tb_dcpll_ctrl;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [`DCPLL_ADDR_W-1:0] reg_addr_i = '0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] reg_rdata_o;
    logic ref_tick_i = 1'b0;
    logic vco_fast_i = 1'b0;
    logic pll_lock_i = 1'b0;
    logic tune_upper_i = 1'b0;
    logic tune_lower_i = 1'b0;
    logic pll_enable_o;
    logic cp_cal_run_o;
    logic [8:0] band_select_o;
    logic [7:0] loop_divide_count_o;
    logic [4:0] oscillator_output_divide_ratio_o;
    logic [4:0] reference_divide_ratio_o;
    logic [7:0] tune_a_o;
    logic [7:0] tune_b_o;
    logic [7:0] tune_c_o;
    logic irq_o;
    int n_fail = 0;
    int checked = 0;
    int cyc = 0;
    int cp_ticks = 0;
    logic [1:0] tick_div = 2'h0;
    logic [8:0] target = 9'h15a;
    logic [11:0] addrs [10] = '{12'h01f, 12'h023, 12'h083, 12'h084, 12'h085, 12'h08b,
                                12'h08c, 12'h1b5, 12'h1bb, 12'h1c5};
    logic [4:0] osc_exp [4] = '{5'h00, 5'h04, 5'h08, 5'h10};
    logic [4:0] ref_exp [8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h00, 5'h00, 5'h00};

    dcpll_ctrl i_dut (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(reg_rdata_o),
        .ref_tick_i(ref_tick_i),
        .vco_fast_i(vco_fast_i),
        .pll_lock_i(pll_lock_i),
        .tune_upper_i(tune_upper_i),
        .tune_lower_i(tune_lower_i),
        .pll_enable_o(pll_enable_o),
        .cp_cal_run_o(cp_cal_run_o),
        .band_select_o(band_select_o),
        .loop_divide_count_o(loop_divide_count_o),
        .oscillator_output_divide_ratio_o(oscillator_output_divide_ratio_o),
        .reference_divide_ratio_o(reference_divide_ratio_o),
        .tune_a_o(tune_a_o),
        .tune_b_o(tune_b_o),
        .tune_c_o(tune_c_o),
        .irq_o(irq_o)
    );

    initial begin
        forever #10 core_clk_i = ~core_clk_i;
    end

    // free-running reference tick, one core cycle in four
    always @(negedge core_clk_i) begin
        tick_div <= tick_div + 2'h1;
        ref_tick_i <= (tick_div == 2'h3);
        vco_fast_i <= (band_select_o > target); // crude oscillator: fast above target band
    end

    always @(posedge core_clk_i) begin
        if (cp_cal_run_o === 1'b1 && ref_tick_i) begin
            cp_ticks <= cp_ticks + 1;
        end
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            stop_test();
        end
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        @(negedge core_clk_i);
        reg_wr_i = 1'b0;
        // one quiet edge so the next call never re-raises the strobe in this time step
        @(negedge core_clk_i);
    endtask : wr

    // data is taken at the falling edge after the read edge, where it is settled
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        @(negedge core_clk_i);
        reg_rd_i = 1'b0;
        d = reg_rdata_o;
        @(negedge core_clk_i);
    endtask : rd

    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check($sformatf("reg %h", a), {8'h00, d}, {8'h00, exp});
    endtask : rdc

    task automatic idle(input int n);
        repeat (n) @(negedge core_clk_i);
    endtask : idle

    // bounded poll of the calibration-done flag
    task automatic wait_cal();
        logic [7:0] v;
        int k;
        v = 8'h00;
        for (k = 0; k < 400 && v[5] !== 1'b1; k++) begin
            rd(12'h084, v);
        end
        check("cal done", {15'h0000, v[5]}, 16'h0001);
    endtask : wait_cal

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20) @(negedge core_clk_i);
        sys_rst_i = 1'b0;
        check("ref ratio at reset", {11'h000, reference_divide_ratio_o}, 16'h0001);
        check("enable at reset", {15'h0000, pll_enable_o}, 16'h0000);
        for (int i = 0; i < 10; i++) begin
            rdc(addrs[i], 8'h00);
        end
        wr(12'h100, 8'hff);
        rdc(12'h100, 8'h00);
        wr(12'h084, 8'hff);
        rdc(12'h084, 8'h00);
        for (int i = 0; i < 4; i++) begin
            wr(12'h08b, 8'(i));
            check("osc ratio", {11'h000, oscillator_output_divide_ratio_o}, {11'h000, osc_exp[i]});
        end
        for (int i = 0; i < 8; i++) begin
            wr(12'h08c, 8'(i));
            check("ref ratio", {11'h000, reference_divide_ratio_o}, {11'h000, ref_exp[i]});
        end
        // fixed settings live outside this block; the write must be harmless
        wr(12'h087, 8'h62);
        wr(12'h08b, 8'h02);
        wr(12'h085, 8'h10);
        wr(12'h08c, 8'h03);
        wr(12'h1b5, 8'h09);
        wr(12'h1bb, 8'h13);
        wr(12'h1c5, 8'h06);
        rdc(12'h085, 8'h10);
        rdc(12'h08c, 8'h03);
        rdc(12'h1bb, 8'h13);
        check("loop count", {8'h00, loop_divide_count_o}, 16'h0010);
        check("tune", {tune_a_o, tune_c_o}, 16'h0906);
        check("tune b", {8'h00, tune_b_o}, 16'h0013);
        wr(12'h083, 8'h10);
        check("pll enable", {15'h0000, pll_enable_o}, 16'h0001);
        idle(2);
        check("cp cal running", {15'h0000, cp_cal_run_o}, 16'h0001);
        wait_cal();
        check("cp cal ticks", 16'(cp_ticks), 16'd64);
        check("band", {7'h00, band_select_o}, {7'h00, target});
        rdc(12'h084, 8'h20);
        pll_lock_i = 1'b1;
        idle(4);
        rdc(12'h084, 8'h22);
        check("irq masked", {15'h0000, irq_o}, 16'h0000);
        rdc(12'h023, 8'h20);
        wr(12'h01f, 8'h30);
        rdc(12'h01f, 8'h30);
        check("irq lock", {15'h0000, irq_o}, 16'h0001);
        wr(12'h023, 8'h20);
        rdc(12'h023, 8'h00);
        check("irq cleared", {15'h0000, irq_o}, 16'h0000);
        pll_lock_i = 1'b0;
        idle(4);
        rdc(12'h023, 8'h10);
        check("irq lost", {15'h0000, irq_o}, 16'h0001);
        wr(12'h01f, 8'h20);
        check("lost masked", {15'h0000, irq_o}, 16'h0000);
        wr(12'h023, 8'h10);
        pll_lock_i = 1'b1;
        tune_upper_i = 1'b1;
        idle(4);
        rdc(12'h084, 8'ha2);
        tune_upper_i = 1'b0;
        tune_lower_i = 1'b1;
        idle(2);
        rdc(12'h084, 8'h62);
        tune_lower_i = 1'b0;
        wr(12'h023, 8'h30);
        // recalibrate towards a new band; the charge pump result must be reused
        target = 9'h0a5;
        wr(12'h083, 8'h10);
        wr(12'h083, 8'h90);
        idle(1);
        rdc(12'h084, 8'h00);
        wait_cal();
        check("band after recal", {7'h00, band_select_o}, 16'h00a5);
        check("cp ticks kept", 16'(cp_ticks), 16'd64);
        wr(12'h083, 8'h00);
        check("pll disabled", {15'h0000, pll_enable_o}, 16'h0000);
        rdc(12'h084, 8'h00);
        wr(12'h083, 8'h10);
        idle(2);
        check("no second cp cal", {15'h0000, cp_cal_run_o}, 16'h0000);
        wait_cal();
        check("band again", {7'h00, band_select_o}, 16'h00a5);
        stop_test();
    end
endmodule : tb_dcpll_ctrl
`default_nettype wire
